// ==== shared/dspos_pkg.sv ====
package dspos_pkg;
  localparam int A_W = 30;
  localparam int B_W = 18;
  localparam int C_W = 48;
  localparam int MA_W = 25;
  localparam int PP_W = 43;
  localparam int SHIFT_N = 17;
  localparam int OPM_W = 7;
  localparam int ALU_W = 4;
  localparam int CSEL_W = 3;
  // register map, byte addresses
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RES_LO = 4'h8;
  localparam logic [3:0] ADDR_RES_HI = 4'hc;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // configuration fields
  localparam int F_A_DEPTH = 0;
  localparam int F_B_DEPTH = 2;
  localparam int F_A_CDEPTH = 4;
  localparam int F_B_CDEPTH = 6;
  localparam int F_C_DEPTH = 8;
  localparam int F_PROD_REG = 9;
  localparam int F_OPM_REG = 10;
  localparam int F_ALU_REG = 11;
  localparam int F_CSEL_REG = 12;
  localparam int F_A_SRC = 13;
  localparam int F_B_SRC = 14;
  // status fields
  localparam int S_OPM = 0;
  localparam int S_ALU = 8;
  localparam int S_CSEL = 12;
  // arithmetic modes
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_NZADD = 4'h1;
  localparam logic [3:0] ALU_NSUM = 4'h2;
  localparam logic [3:0] ALU_SUB = 4'h3;
  // multiplexer selects
  localparam logic [1:0] XY_ZERO = 2'h0;
  localparam logic [1:0] XY_PROD = 2'h1;
  localparam logic [1:0] X_RES = 2'h2;
  localparam logic [1:0] X_CAT = 2'h3;
  localparam logic [1:0] Y_ONES = 2'h2;
  localparam logic [1:0] Y_THIRD = 2'h3;
  localparam logic [2:0] Z_ZERO = 3'h0;
  localparam logic [2:0] Z_CASC = 3'h1;
  localparam logic [2:0] Z_RES = 3'h2;
  localparam logic [2:0] Z_THIRD = 3'h3;
  localparam logic [2:0] Z_MULTIPLY_ACCUMULATE = 3'h4;
  localparam logic [2:0] Z_SCASC = 3'h5;
  localparam logic [2:0] Z_SRES = 3'h6;
  typedef logic [C_W-1:0] dspos_word_t;
endpackage : dspos_pkg

// ==== rtl/dspos_pipe.sv ====
`timescale 1ns/1ps
module dspos_pipe #(
  parameter int W = 30
) (
  // clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic rst,
  // data and enables
  input wire logic [W-1:0] d,
  input wire logic en1,
  input wire logic en2,
  // depth settings, already legal
  input wire logic [1:0] depth,
  input wire logic [1:0] cdepth,
  // direct and cascade outputs
  output logic [W-1:0] q,
  output logic [W-1:0] cq
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  // depth 1 uses only the second stage
  assign s2_d = (depth == 2'd2) ? s1_q : d;

  always_ff @(posedge clk) begin
    if (!nrst || rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      if (en1) s1_q <= d;
      if (en2) s2_q <= s2_d;
    end
  end

  assign q = (depth == 2'd0) ? d : s2_q;
  assign cq = (depth == 2'd2 && cdepth == 2'd1) ? s1_q : q;
endmodule : dspos_pipe

// ==== rtl/dspos_slice.sv ====
`timescale 1ns/1ps
module dspos_slice (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // direct operands
  input wire logic [dspos_pkg::A_W-1:0] FIRST_OPERAND,
  input wire logic [dspos_pkg::B_W-1:0] SECOND_OPERAND,
  input wire logic [dspos_pkg::C_W-1:0] THIRD_OPERAND,
  // cascade operands
  input wire logic [dspos_pkg::A_W-1:0] FIRST_OPERAND_CASCADE_IN,
  input wire logic [dspos_pkg::B_W-1:0] SECOND_OPERAND_CASCADE_IN,
  input wire logic [dspos_pkg::C_W-1:0] CASCADE_RESULT_IN,
  output logic [dspos_pkg::A_W-1:0] FIRST_OPERAND_CASCADE_OUT,
  output logic [dspos_pkg::B_W-1:0] SECOND_OPERAND_CASCADE_OUT,
  // operand enables and resets
  input wire logic FIRST_OPERAND_STAGE1_ENABLE,
  input wire logic FIRST_OPERAND_STAGE2_ENABLE,
  input wire logic SECOND_OPERAND_STAGE1_ENABLE,
  input wire logic SECOND_OPERAND_STAGE2_ENABLE,
  input wire logic FIRST_OPERAND_RESET,
  input wire logic SECOND_OPERAND_RESET,
  input wire logic THIRD_OPERAND_ENABLE,
  input wire logic THIRD_OPERAND_RESET,
  input wire logic PRODUCT_ENABLE,
  input wire logic PRODUCT_RESET,
  // control words
  input wire logic [dspos_pkg::OPM_W-1:0] OPERATING_MODE,
  input wire logic [dspos_pkg::ALU_W-1:0] ARITHMETIC_MODE,
  input wire logic [dspos_pkg::CSEL_W-1:0] CARRY_SOURCE_SELECT,
  input wire logic CARRY_INPUT,
  input wire logic CONTROL_ENABLE,
  input wire logic ARITH_MODE_ENABLE,
  input wire logic CONTROL_REGISTER_RESET,
  input wire logic ARITH_MODE_RESET,
  // result
  input wire logic RESULT_ENABLE,
  input wire logic RESULT_RESET,
  output logic [dspos_pkg::C_W-1:0] RESULT,
  output logic [dspos_pkg::C_W-1:0] PATTERN_OPERAND
);
  import dspos_pkg::*;

  function automatic dspos_word_t shift17(input dspos_word_t v);
    shift17 = dspos_word_t'($signed(v) >>> SHIFT_N);
  endfunction : shift17

  function automatic logic [1:0] legal_depth(input logic [1:0] v);
    legal_depth = (v == 2'd3) ? 2'd2 : v;
  endfunction : legal_depth

  function automatic logic [1:0] legal_cdepth(input logic [1:0] dep,
                                              input logic [1:0] v);
    if (dep != 2'd2) legal_cdepth = dep;
    else legal_cdepth = (v == 2'd2) ? 2'd2 : 2'd1;
  endfunction : legal_cdepth

  function automatic dspos_word_t pp_ext(input logic [PP_W-1:0] v);
    pp_ext = {{(C_W-PP_W){v[PP_W-1]}}, v};
  endfunction : pp_ext

  // configuration and bus state
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire bus_req = AVS_READ | AVS_WRITE;
  wire wr_take = AVS_WRITE & ack_q;
  wire rd_load = AVS_READ & ~ack_q;
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                         {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // configuration fields
  wire [1:0] a_depth = legal_depth(cfg_q[F_A_DEPTH +: 2]);
  wire [1:0] b_depth = legal_depth(cfg_q[F_B_DEPTH +: 2]);
  wire [1:0] a_cdepth = legal_cdepth(a_depth, cfg_q[F_A_CDEPTH +: 2]);
  wire [1:0] b_cdepth = legal_cdepth(b_depth, cfg_q[F_B_CDEPTH +: 2]);
  wire c_reg_on = cfg_q[F_C_DEPTH];
  wire prod_reg_on = cfg_q[F_PROD_REG];
  wire opm_reg_on = cfg_q[F_OPM_REG];
  wire alu_reg_on = cfg_q[F_ALU_REG];
  wire csel_reg_on = cfg_q[F_CSEL_REG];

  // operand paths
  wire [A_W-1:0] a_in = cfg_q[F_A_SRC] ? FIRST_OPERAND_CASCADE_IN
                                       : FIRST_OPERAND;
  wire [B_W-1:0] b_in = cfg_q[F_B_SRC] ? SECOND_OPERAND_CASCADE_IN
                                       : SECOND_OPERAND;
  logic [A_W-1:0] a_op;
  logic [B_W-1:0] b_op;
  logic [C_W-1:0] c_q;
  wire [C_W-1:0] c_op = c_reg_on ? c_q : THIRD_OPERAND;

  // control registers
  logic [OPM_W-1:0] opm_q;
  logic [ALU_W-1:0] alu_q;
  logic [CSEL_W-1:0] csel_q;
  wire [OPM_W-1:0] opm = opm_reg_on ? opm_q : OPERATING_MODE;
  wire [ALU_W-1:0] alu = alu_reg_on ? alu_q : ARITHMETIC_MODE;
  wire [CSEL_W-1:0] csel = csel_reg_on ? csel_q : CARRY_SOURCE_SELECT;
  wire [1:0] x_sel = opm[1:0];
  wire [1:0] y_sel = opm[3:2];
  wire [2:0] z_sel = opm[6:4];

  // multiplier partial products
  logic signed [MA_W+9:0] pp_lo_raw;
  logic signed [MA_W+8:0] pp_hi_raw;
  wire [PP_W-1:0] pp_lo = {{(PP_W-MA_W-10){pp_lo_raw[MA_W+9]}}, pp_lo_raw};
  wire [PP_W-1:0] pp_hi = {pp_hi_raw, 9'h000};
  logic [PP_W-1:0] pp_lo_q;
  logic [PP_W-1:0] pp_hi_q;
  wire [PP_W-1:0] m_lo = prod_reg_on ? pp_lo_q : pp_lo;
  wire [PP_W-1:0] m_hi = prod_reg_on ? pp_hi_q : pp_hi;

  // multiplexers and adder
  logic [C_W-1:0] result_q;
  logic [C_W-1:0] x_mux;
  logic [C_W-1:0] y_mux;
  logic [C_W-1:0] z_mux;
  logic [C_W-1:0] alu_out;
  wire [C_W-1:0] ab_cat = {a_op, b_op};
  wire [C_W-1:0] xyc = x_mux + y_mux + C_W'(CARRY_INPUT);

  dspos_pipe #(.W(A_W)) u_first_pipe (
    .clk(CORE_CLK),
    .nrst(NRST),
    .rst(FIRST_OPERAND_RESET),
    .d(a_in),
    .en1(FIRST_OPERAND_STAGE1_ENABLE),
    .en2(FIRST_OPERAND_STAGE2_ENABLE),
    .depth(a_depth),
    .cdepth(a_cdepth),
    .q(a_op),
    .cq(FIRST_OPERAND_CASCADE_OUT)
  );

  dspos_pipe #(.W(B_W)) u_second_pipe (
    .clk(CORE_CLK),
    .nrst(NRST),
    .rst(SECOND_OPERAND_RESET),
    .d(b_in),
    .en1(SECOND_OPERAND_STAGE1_ENABLE),
    .en2(SECOND_OPERAND_STAGE2_ENABLE),
    .depth(b_depth),
    .cdepth(b_cdepth),
    .q(b_op),
    .cq(SECOND_OPERAND_CASCADE_OUT)
  );

  // split multiply: low 9 bits unsigned, high 9 bits signed
  always_comb begin
    pp_lo_raw = $signed(a_op[MA_W-1:0]) * $signed({1'b0, b_op[8:0]});
    pp_hi_raw = $signed(a_op[MA_W-1:0]) * $signed(b_op[B_W-1:9]);
  end

  always_comb begin
    case (x_sel)
      XY_ZERO: x_mux = '0;
      XY_PROD: x_mux = pp_ext(m_lo);
      X_RES: x_mux = result_q;
      X_CAT: x_mux = ab_cat;
      default: x_mux = '0;
    endcase
  end

  always_comb begin
    case (y_sel)
      XY_ZERO: y_mux = '0;
      XY_PROD: y_mux = pp_ext(m_hi);
      Y_ONES: y_mux = '1;
      Y_THIRD: y_mux = c_op;
      default: y_mux = '0;
    endcase
  end

  // 111 is illegal and yields zero here
  always_comb begin
    case (z_sel)
      Z_ZERO: z_mux = '0;
      Z_CASC: z_mux = CASCADE_RESULT_IN;
      Z_RES: z_mux = result_q;
      Z_THIRD: z_mux = c_op;
      Z_MULTIPLY_ACCUMULATE: z_mux = result_q;
      Z_SCASC: z_mux = shift17(CASCADE_RESULT_IN);
      Z_SRES: z_mux = shift17(result_q);
      default: z_mux = '0;
    endcase
  end

  // other arithmetic modes fall back to plain add
  always_comb begin
    case (alu)
      ALU_ADD: alu_out = z_mux + xyc;
      ALU_SUB: alu_out = z_mux - xyc;
      ALU_NZADD: alu_out = ~z_mux + xyc;
      ALU_NSUM: alu_out = ~(z_mux + xyc);
      default: alu_out = z_mux + xyc;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || THIRD_OPERAND_RESET) c_q <= '0;
    else if (THIRD_OPERAND_ENABLE) c_q <= THIRD_OPERAND;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || PRODUCT_RESET) begin
      pp_lo_q <= '0;
      pp_hi_q <= '0;
    end else if (PRODUCT_ENABLE) begin
      pp_lo_q <= pp_lo;
      pp_hi_q <= pp_hi;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || CONTROL_REGISTER_RESET) begin
      opm_q <= '0;
      csel_q <= '0;
    end else if (CONTROL_ENABLE) begin
      opm_q <= OPERATING_MODE;
      csel_q <= CARRY_SOURCE_SELECT;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || ARITH_MODE_RESET) alu_q <= '0;
    else if (ARITH_MODE_ENABLE) alu_q <= ARITHMETIC_MODE;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || RESULT_RESET) result_q <= '0;
    else if (RESULT_ENABLE) result_q <= alu_out;
  end

  assign RESULT = result_q;
  assign PATTERN_OPERAND = c_op;

  // register bus: one wait cycle per access
  always_comb begin
    case (AVS_ADDRESS)
      ADDR_CFG: rdata_d = cfg_q;
      ADDR_STATUS: rdata_d = {17'h00000, csel, alu, 1'b0, opm};
      ADDR_RES_LO: rdata_d = result_q[31:0];
      ADDR_RES_HI: rdata_d = {16'h0000, result_q[C_W-1:32]};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  assign cfg_d = (wr_take && AVS_ADDRESS == ADDR_CFG)
               ? ((cfg_q & ~be_mask) | (AVS_WRITEDATA & be_mask)) : cfg_q;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cfg_q <= CFG_RESET;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      ack_q <= bus_req & ~ack_q;
      if (rd_load) rdata_q <= rdata_d;
    end
  end

  assign AVS_WAITREQUEST = bus_req & ~ack_q;
  assign AVS_READDATA = rdata_q;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  wire [C_W-1:0] chk_prod = C_W'($signed(a_op[MA_W-1:0]) * $signed(b_op));
  wire [C_W-1:0] chk_sum = pp_ext(pp_lo) + pp_ext(pp_hi);
  wire res_load = RESULT_ENABLE & ~RESULT_RESET;

  sequence s_a_rst2;
    FIRST_OPERAND_RESET [*2];
  endsequence

  sequence s_a_hold;
    !FIRST_OPERAND_RESET && !FIRST_OPERAND_STAGE1_ENABLE
      && !FIRST_OPERAND_STAGE2_ENABLE && !wr_take;
  endsequence

  AST_MULT_PRODUCT: assert property (
    chk_sum == chk_prod)
    else $error("partial products do not sum to the product");

  AST_X_CONCAT: assert property (
    x_sel == X_CAT |-> x_mux == {a_op, b_op})
    else $error("X concatenated operand wrong");

  AST_Y_ONES: assert property (
    y_sel == Y_ONES |-> y_mux == {C_W{1'b1}})
    else $error("Y all-ones select wrong");

  AST_Z_SHIFT: assert property (
    z_sel == Z_SCASC |-> z_mux[C_W-1:C_W-SHIFT_N-1] == {(SHIFT_N+1)
      {CASCADE_RESULT_IN[C_W-1]}})
    else $error("shifted cascade sign not replicated");

  AST_ADD_RESULT: assert property (
    res_load && alu == ALU_ADD |=>
      result_q == $past(z_mux) + $past(x_mux) + $past(y_mux)
        + C_W'($past(CARRY_INPUT)))
    else $error("add mode result wrong");

  AST_SUB_RESULT: assert property (
    res_load && alu == ALU_SUB |=>
      result_q == $past(z_mux) - $past(xyc))
    else $error("subtract mode result wrong");

  AST_NZ_RESULT: assert property (
    res_load && alu == ALU_NZADD |=>
      result_q == ~$past(z_mux) + $past(xyc))
    else $error("inverted Z add result wrong");

  AST_NSUM_RESULT: assert property (
    res_load && alu == ALU_NSUM |=>
      result_q == ~($past(z_mux) + $past(xyc)))
    else $error("inverted sum result wrong");

  AST_OPM_REG: assert property (
    CONTROL_ENABLE && !CONTROL_REGISTER_RESET |=>
      opm_q == $past(OPERATING_MODE))
    else $error("operating mode register missed a load");

  AST_A_RESET: assert property (
    s_a_rst2 |=> a_depth == 2'd0 || a_op == '0)
    else $error("first operand not cleared by its reset");

  AST_A_HOLD: assert property (
    (a_depth != 2'd0) and s_a_hold |=> $stable(a_op))
    else $error("first operand stage moved without enable");

  AST_MULTIPLY_ACCUMULATE_Z: assert property (
    z_sel == Z_MULTIPLY_ACCUMULATE |-> z_mux == result_q)
    else $error("Z select 100 not the result");

  AST_BUS_ACK: assert property (
    bus_req && !ack_q |=> !AVS_WAITREQUEST || !bus_req)
    else $error("bus answer later than one wait cycle");
endmodule : dspos_slice

// ==== dv/dspos_neighbor.sv ====
`timescale 1ns/1ps
module dspos_neighbor (
  // settings seen by the driving logic
  input wire logic [1:0] depth,
  input wire logic prod_reg,
  // requests
  input wire logic want,
  input wire logic [31:0] rnd,
  // drives into the slice
  output logic en1,
  output logic en2,
  output logic [6:0] opmode
);
  logic [1:0] x_raw;
  logic [1:0] x_sel;
  logic [1:0] y_sel;
  logic [2:0] z_sel;
  assign en1 = want & (depth == 2'h2);
  assign en2 = want & (depth != 2'h0);
  // only legal mux combinations leave here
  assign z_sel = (rnd[2:0] == 3'h7) ? 3'h0 :
    (rnd[2:0] == 3'h4) ? 3'h6 : rnd[2:0];
  assign x_raw = (rnd[4:3] == 2'h1) ? 2'h3 : rnd[4:3];
  assign x_sel = (prod_reg && depth == 2'h0 && x_raw == 2'h3) ? 2'h0 :
    x_raw;
  assign y_sel = (rnd[6:5] == 2'h1) ? 2'h3 : rnd[6:5];
  assign opmode = (rnd[9:7] == 3'h0) ? {z_sel, 2'h1, 2'h1} :
    (rnd[9:7] == 3'h1) ? 7'h48 : {z_sel, y_sel, x_sel};
endmodule : dspos_neighbor

// ==== dv/dsp_slice_operand_select_alu_tb.sv ====
`timescale 1ns/1ps
module dsp_slice_operand_select_alu_tb;
  import dspos_pkg::*;
  logic clk, nrst, av_rd, av_wr, av_wait, rst_a, rst_b, c_en, c_rst;
  logic m_en, m_rst, ctl_en, alu_en, ctl_rst, alu_rst, r_en, r_rst, cin;
  logic want, en1, en2, man, prod_reg;
  logic [3:0] av_adr, be, alu;
  logic [31:0] av_wd, av_rdata, rnd, rd;
  logic [29:0] a_in, ac_in, a_cout, va;
  logic [17:0] b_in, bc_in, b_cout, vb;
  logic [6:0] opm, opm_man, op_drv;
  logic [2:0] csel;
  logic [1:0] depth;
  dspos_word_t c_in, pc_in, result, pat, e1;
  int seed = 34264;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign op_drv = man ? opm_man : opm;

  dspos_neighbor nb (.depth(depth), .prod_reg(prod_reg), .want(want),
    .rnd(rnd), .en1(en1), .en2(en2), .opmode(opm));

  dspos_slice DUT (.CORE_CLK(clk), .NRST(nrst), .AVS_ADDRESS(av_adr),
    .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait), .FIRST_OPERAND(a_in),
    .SECOND_OPERAND(b_in), .THIRD_OPERAND(c_in),
    .FIRST_OPERAND_CASCADE_IN(ac_in), .SECOND_OPERAND_CASCADE_IN(bc_in),
    .CASCADE_RESULT_IN(pc_in), .FIRST_OPERAND_CASCADE_OUT(a_cout),
    .SECOND_OPERAND_CASCADE_OUT(b_cout),
    .FIRST_OPERAND_STAGE1_ENABLE(en1), .FIRST_OPERAND_STAGE2_ENABLE(en2),
    .SECOND_OPERAND_STAGE1_ENABLE(en1), .SECOND_OPERAND_STAGE2_ENABLE(en2),
    .FIRST_OPERAND_RESET(rst_a), .SECOND_OPERAND_RESET(rst_b),
    .THIRD_OPERAND_ENABLE(c_en), .THIRD_OPERAND_RESET(c_rst),
    .PRODUCT_ENABLE(m_en), .PRODUCT_RESET(m_rst), .OPERATING_MODE(op_drv),
    .ARITHMETIC_MODE(alu), .CARRY_SOURCE_SELECT(csel), .CARRY_INPUT(cin),
    .CONTROL_ENABLE(ctl_en), .ARITH_MODE_ENABLE(alu_en),
    .CONTROL_REGISTER_RESET(ctl_rst), .ARITH_MODE_RESET(alu_rst),
    .RESULT_ENABLE(r_en), .RESULT_RESET(r_rst), .RESULT(result),
    .PATTERN_OPERAND(pat));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [47:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] adr,
      input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    av_rd <= !wr;
    av_wr <= wr;
    av_adr <= adr;
    av_wd <= wd;
    @(posedge clk);
    while (av_wait !== 1'b0) @(posedge clk);
    d = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  function automatic dspos_word_t calc(input logic [29:0] a,
      input logic [17:0] b, input dspos_word_t c, pc, p,
      input logic [6:0] om, input logic [3:0] md, input logic ci);
    dspos_word_t x, y, z, s;
    logic signed [47:0] m;
    m = $signed(a[24:0]) * $signed(b);
    x = (om[1:0] == 2'h1) ? m : (om[1:0] == 2'h2) ? p :
      (om[1:0] == 2'h3) ? {a, b} : '0;
    y = (om[3:2] == 2'h2) ? '1 : (om[3:2] == 2'h3) ? c : '0;
    z = (om[6:4] == Z_CASC) ? pc : (om[6:4] == Z_THIRD) ? c :
      (om[6:4] == Z_RES || om[6:4] == Z_MULTIPLY_ACCUMULATE) ? p : '0;
    if (om[6:4] == Z_SCASC) z = $unsigned($signed(pc) >>> SHIFT_N);
    if (om[6:4] == Z_SRES) z = $unsigned($signed(p) >>> SHIFT_N);
    s = x + y + 48'(ci);
    if (md == ALU_SUB) return z - s;
    if (md == ALU_NZADD) return ~z + s;
    if (md == ALU_NSUM) return ~(z + s);
    return z + s;
  endfunction : calc

  initial begin
    {nrst, av_rd, av_wr, rst_a, rst_b, c_en, c_rst, m_en, m_rst} = '0;
    {ctl_en, alu_en, ctl_rst, alu_rst, r_en, r_rst, cin, want} = '0;
    {man, prod_reg, av_adr, av_wd, alu, csel, depth, rnd} = '0;
    {a_in, ac_in, b_in, bc_in, c_in, pc_in, opm_man} = '0;
    be = 4'hf;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    r_en <= 1'b1;
    e1 = '0;
    for (int i = 0; i < 240; i++) begin
      @(posedge clk);
      check("result", result, e1);
      check("pattern", pat, c_in);
      check("casc_a", 48'(a_cout), 48'(a_in));
      e1 = calc(a_in, b_in, c_in, pc_in, e1, op_drv, alu, cin);
      rnd <= $random(seed);
      alu <= 4'(i % 4);
      cin <= 1'($random(seed));
      a_in <= 30'($random(seed));
      b_in <= 18'($random(seed));
      c_in <= 48'({$random(seed), $random(seed)});
      // sign-heavy cascade values for the shift paths
      pc_in <= (i < 40) ? 48'h8000_0000_0000 | 48'(i) :
        48'({$random(seed), $random(seed)});
    end
    va = 30'h1555_aaaa;
    vb = 18'h2_5a5a;
    for (int d = 1; d <= 2; d++) begin
      bus(1'b1, ADDR_CFG, (d == 1) ? 32'h55 : 32'haa, rd);
      bus(1'b0, ADDR_CFG, 32'h0, rd);
      check("cfg", 48'(rd), (d == 1) ? 48'h55 : 48'haa);
      @(posedge clk);
      depth <= 2'(d);
      want <= 1'b1;
      a_in <= va;
      b_in <= vb;
      repeat (d) @(posedge clk);
      check("casc_early", 48'(a_cout), 48'h0);
      want <= 1'b0;
      a_in <= ~va;
      b_in <= ~vb;
      repeat (2) begin
        @(posedge clk);
        check("casc_a", 48'(a_cout), 48'(va));
        check("casc_b", 48'(b_cout), 48'(vb));
      end
      rst_a <= 1'b1;
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      rst_a <= 1'b0;
      rst_b <= 1'b0;
      @(posedge clk);
      check("casc_rst", 48'({a_cout, b_cout}), 48'h0);
    end
    // cascade sources, third and product registers, depth 0
    bus(1'b1, ADDR_CFG, 32'h0000_6300, rd);
    e1 = calc(va, vb, '0, '0, '0, 7'h05, ALU_ADD, 1'b0);
    @(posedge clk);
    man <= 1'b1;
    opm_man <= 7'h05;
    {alu, cin} <= '0;
    ac_in <= va;
    bc_in <= vb;
    c_in <= 48'h1234_5678_9abc;
    {m_en, c_en} <= 2'b11;
    repeat (2) @(posedge clk);
    {m_en, c_en} <= 2'b00;
    c_in <= 48'h0;
    @(posedge clk);
    check("prod_reg", result, e1);
    check("third_reg", pat, 48'h1234_5678_9abc);
    check("casc_src", 48'({a_cout, b_cout}), 48'({va, vb}));
    bus(1'b1, ADDR_RES_LO, 32'hffff_ffff, rd);
    bus(1'b0, ADDR_RES_LO, 32'h0, rd);
    check("res_lo", 48'(rd), 48'(e1[31:0]));
    bus(1'b0, ADDR_RES_HI, 32'h0, rd);
    check("res_hi", 48'(rd), 48'(e1[47:32]));
    bus(1'b1, ADDR_CFG, 32'h0000_0c00, rd);
    @(posedge clk);
    man <= 1'b1;
    opm_man <= 7'h35;
    alu <= ALU_SUB;
    ctl_en <= 1'b1;
    alu_en <= 1'b1;
    @(posedge clk);
    {ctl_en, alu_en, opm_man, alu} <= '0;
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    check("opm_reg", 48'(rd[6:0]), 48'h35);
    check("alu_reg", 48'(rd[11:8]), 48'h3);
    @(posedge clk);
    ctl_rst <= 1'b1;
    @(posedge clk);
    ctl_rst <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    check("opm_clr", 48'(rd[6:0]), 48'h0);
    check("alu_kept", 48'(rd[11:8]), 48'h3);
    @(posedge clk);
    alu_rst <= 1'b1;
    @(posedge clk);
    alu_rst <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    check("alu_clr", 48'(rd[11:8]), 48'h0);
    bus(1'b0, 4'h1, 32'h0, rd);
    check("unmapped", 48'(rd), 48'h0);
    complete_run();
  end
endmodule : dsp_slice_operand_select_alu_tb
